// ---- hw/vref_defs.svh ----
/*
  register offsets, field positions, reset values and timing counts for the
  reference/temperature control block. assumes an 8-bit register port.
*/
`ifndef VREF_DEFS_SVH
`define VREF_DEFS_SVH

`define VREF_ADDR_CTRL        8'h00
`define VREF_ADDR_RES_HIGH    8'h01
`define VREF_ADDR_RES_LOW     8'h02
`define VREF_ADDR_CONV        8'h03

`define VREF_CTRL_REF_EN      7
`define VREF_CTRL_READY       6
`define VREF_CTRL_TEMP_EN     5
`define VREF_CTRL_TEMP_RANGE  4
`define VREF_CTRL_GAIN_HI     1
`define VREF_CTRL_GAIN_LO     0

`define VREF_CONV_GO          0
`define VREF_CONV_ON          1
`define VREF_CONV_DONE_FLAG   2
`define VREF_CONV_IRQ_EN      3
`define VREF_CONV_RIGHT_JUST  4

`define VREF_GAIN_OFF         2'h0
`define VREF_RESET_BYTE       8'h00

`define VREF_CLK_PERIOD_NS    40
`define VREF_SETTLE_TIME_NS   25000
`define VREF_SETTLE_CYCLES    ((`VREF_SETTLE_TIME_NS + `VREF_CLK_PERIOD_NS - 1) / `VREF_CLK_PERIOD_NS)
`define VREF_RESULT_BITS      10

`endif

// ---- hw/vref_pkg.sv ----
/*
  types shared by the control block and its successive approximation engine.
  assumes vref_defs.svh is compiled alongside.
*/
package vref_pkg;

  typedef enum logic [1:0] {SAR_IDLE, SAR_TRIAL, SAR_DECIDE} sar_state_t;

  typedef struct packed {
    sar_state_t  state;
    logic [9:0]  code;
    logic [3:0]  bit_idx;
    logic        last_bit;
    logic        decided_any;
    logic [9:0]  result;
    logic [9:0]  trial;
    logic        done;
    logic        partial;
    logic        busy;
  } sar_t;

  typedef struct packed {
    logic        ref_en;
    logic        temp_en;
    logic        temp_range;
    logic [1:0]  gain;
    logic [15:0] settle_cnt;
    logic        ready;
    logic        ref_path_on;
    logic        conv_on;
    logic        go;
    logic        done_flag;
    logic        irq_en;
    logic        right_just;
    logic [7:0]  res_high;
    logic [7:0]  res_low;
    logic [7:0]  rd_data;
    logic        irq;
    logic        wake;
    logic        start;
    logic        abort;
  } ctrl_t;

endpackage

// ---- hw/sar_engine.sv ----
/*
  successive approximation sequencer: drives a trial code to the dac and reads
  the comparator one cycle later, msb first. assumes the comparator settles in
  one clock and that start and abort are single-cycle pulses.
*/
`timescale 1ns/100ps
module sar_engine #(
  parameter int BITS = 10
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             start_in,
  input  wire logic             abort_in,
  input  wire logic             comp_in,
  output logic      [BITS-1:0]  trial_out,
  output logic      [BITS-1:0]  result_out,
  output logic                  done_out,
  output logic                  partial_out,
  output logic                  busy_out
);

  vref_pkg::sar_t s_reg;
  vref_pkg::sar_t s_next;

  // undecided bits copy the last decided bit, zero if none decided yet
  function automatic logic [9:0] fill_low(input logic [9:0] code, input logic [3:0] idx, input logic last);
    logic [9:0] r;
    r = code;
    for (int i = 0; i < 10; i++)
    begin
      if (i <= int'(idx))
      begin
        r[i] = last;
      end
    end
    return r;
  endfunction

  always_comb
  begin
    s_next         = s_reg;
    s_next.done    = 1'b0;
    s_next.partial = 1'b0;
    unique case (s_reg.state)
      vref_pkg::SAR_IDLE:
      begin
        if (start_in)
        begin
          s_next.state       = vref_pkg::SAR_TRIAL;
          s_next.code        = 10'h000;
          s_next.bit_idx     = 4'(BITS - 1);
          s_next.decided_any = 1'b0;
          s_next.last_bit    = 1'b0;
          s_next.busy        = 1'b1;
        end
      end
      vref_pkg::SAR_TRIAL:
      begin
        s_next.trial = s_reg.code | (10'h001 << s_reg.bit_idx);
        s_next.state = vref_pkg::SAR_DECIDE;
      end
      vref_pkg::SAR_DECIDE:
      begin
        s_next.code[s_reg.bit_idx] = comp_in;
        s_next.last_bit            = comp_in;
        s_next.decided_any         = 1'b1;
        if (s_reg.bit_idx == 4'h0)
        begin
          s_next.result = s_reg.code | (comp_in ? 10'h001 : 10'h000);
          s_next.done   = 1'b1;
          s_next.busy   = 1'b0;
          s_next.state  = vref_pkg::SAR_IDLE;
        end
        else
        begin
          s_next.bit_idx = s_reg.bit_idx - 4'h1;
          s_next.state   = vref_pkg::SAR_TRIAL;
        end
      end
      default:
      begin
        s_next.state = vref_pkg::SAR_IDLE;
      end
    endcase
    // abort keeps decided bits; the bit under test is dropped
    if (abort_in && s_reg.busy)
    begin
      s_next.result  = fill_low(s_reg.code, s_reg.bit_idx, s_reg.decided_any & s_reg.last_bit);
      s_next.done    = 1'b1;
      s_next.partial = 1'b1;
      s_next.busy    = 1'b0;
      s_next.state   = vref_pkg::SAR_IDLE;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign trial_out   = s_reg.trial;
  assign result_out  = s_reg.result;
  assign done_out    = s_reg.done;
  assign partial_out = s_reg.partial;
  assign busy_out    = s_reg.busy;

endmodule

// ---- hw/voltage_ref_tempsense_ctrl.sv ----
/*
  control and status for the fixed reference, the temperature indicator and a
  10-bit successive approximation converter, reached over a plain register port.
  assumes the analog reference, sensor, dac and comparator sit outside, and that
  software keeps the sensor acquisition waits itself.
*/
//
// Functional notes
// (RULE_01) writing 1 to the reference enable bit turns the reference on, 0 turns it off.
// (RULE_02) the ready flag rises only after the enabled reference has settled and reads 0 otherwise.
// (RULE_03) on the standard-voltage variant the ready flag always reads 1.
// (RULE_04) the gain field means 00 off, 01 1x, 10 2x and 11 4x for the converter reference.
// (RULE_05) the temperature-sense enable bit turns the temperature indicator on or off.
// (RULE_06) the range select bit picks the high sensor range when 1 and the low range when 0.
// (RULE_07) control bits 3 and 2 are unimplemented, read as 0 and ignore writes.
// (RULE_08) every writable control bit is 0 after any reset.
// (RULE_09) software waits 200 us after routing the converter to the sensor before converting.
// (RULE_10) software leaves 200 us between consecutive sensor conversions.
// (RULE_11) the converter makes a 10-bit result by successive approximation into a high and low register.
// (RULE_12) conversion completion can raise an interrupt that also wakes the device from sleep.
// (RULE_13) clearing the enable holds ready at 0 and setting it again restarts the settling wait.
`timescale 1ns/100ps
`include "vref_defs.svh"
module voltage_ref_tempsense_ctrl #(
  parameter bit STANDARD_VARIANT = 1'b0,
  parameter int SETTLE_CYCLES    = `VREF_SETTLE_CYCLES
) (
  input  wire logic        CLK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic [7:0]  ADDR_IN,
  input  wire logic [7:0]  WR_DATA_IN,
  input  wire logic        WR_STB_IN,
  input  wire logic        RD_STB_IN,
  input  wire logic        COMP_IN,
  input  wire logic        SLEEP_IN,
  output logic      [7:0]  RD_DATA_OUT,
  output logic             REF_ENABLE_OUT,
  output logic             REF_PATH_ON_OUT,
  output logic      [1:0]  REF_GAIN_OUT,
  output logic             TEMP_ENABLE_OUT,
  output logic             TEMP_RANGE_HIGH_OUT,
  output logic      [9:0]  DAC_TRIAL_OUT,
  output logic             CONV_BUSY_OUT,
  output logic             CONV_IRQ_OUT,
  output logic             WAKE_OUT
);

  localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYCLES - 1);

  vref_pkg::ctrl_t c_reg;
  vref_pkg::ctrl_t c_next;

  logic [9:0] sar_result;
  logic       sar_done;
  logic       sar_partial;
  logic       sar_busy;

  function automatic logic [7:0] ctrl_image(input vref_pkg::ctrl_t c);
    logic [7:0] v;
    v                               = `VREF_RESET_BYTE;
    v[`VREF_CTRL_REF_EN]            = c.ref_en;
    v[`VREF_CTRL_READY]             = STANDARD_VARIANT ? 1'b1 : c.ready; // RULE_03
    v[`VREF_CTRL_TEMP_EN]           = c.temp_en;
    v[`VREF_CTRL_TEMP_RANGE]        = c.temp_range;
    v[`VREF_CTRL_GAIN_HI:`VREF_CTRL_GAIN_LO] = c.gain;
    return v; // RULE_07
  endfunction

  function automatic logic [7:0] conv_image(input vref_pkg::ctrl_t c, input logic busy);
    logic [7:0] v;
    v                        = `VREF_RESET_BYTE;
    v[`VREF_CONV_GO]         = c.go | busy;
    v[`VREF_CONV_ON]         = c.conv_on;
    v[`VREF_CONV_DONE_FLAG]  = c.done_flag;
    v[`VREF_CONV_IRQ_EN]     = c.irq_en;
    v[`VREF_CONV_RIGHT_JUST] = c.right_just;
    return v;
  endfunction

  always_comb
  begin
    c_next       = c_reg;
    c_next.start = 1'b0;
    c_next.abort = 1'b0;

    // register writes
    if (WR_STB_IN)
    begin
      unique case (ADDR_IN)
        `VREF_ADDR_CTRL:
        begin
          c_next.ref_en     = WR_DATA_IN[`VREF_CTRL_REF_EN]; // RULE_01
          c_next.temp_en    = WR_DATA_IN[`VREF_CTRL_TEMP_EN]; // RULE_05
          c_next.temp_range = WR_DATA_IN[`VREF_CTRL_TEMP_RANGE]; // RULE_06
          c_next.gain       = WR_DATA_IN[`VREF_CTRL_GAIN_HI:`VREF_CTRL_GAIN_LO];
        end
        `VREF_ADDR_CONV:
        begin
          c_next.conv_on    = WR_DATA_IN[`VREF_CONV_ON];
          c_next.irq_en     = WR_DATA_IN[`VREF_CONV_IRQ_EN];
          c_next.right_just = WR_DATA_IN[`VREF_CONV_RIGHT_JUST];
          if (!WR_DATA_IN[`VREF_CONV_DONE_FLAG])
          begin
            c_next.done_flag = 1'b0;
          end
          // go needs the converter already on; a go in the same write as on is ignored
          if (WR_DATA_IN[`VREF_CONV_GO] && c_reg.conv_on && !c_reg.go && !sar_busy)
          begin
            c_next.go    = 1'b1;
            c_next.start = 1'b1;
          end
          else if (!WR_DATA_IN[`VREF_CONV_GO] && (c_reg.go || sar_busy))
          begin
            c_next.go    = 1'b0;
            c_next.abort = 1'b1;
          end
          if (!WR_DATA_IN[`VREF_CONV_ON] && (c_reg.go || sar_busy))
          begin
            c_next.go    = 1'b0;
            c_next.abort = 1'b1;
          end
        end
        default:
        begin
        end
      endcase
    end

    // settling: counter restarts from zero on every off-to-on change
    if (!c_reg.ref_en)
    begin
      c_next.settle_cnt = 16'h0000; // RULE_13
      c_next.ready      = 1'b0; // RULE_13
    end
    else if (!c_reg.ready)
    begin
      if (c_reg.settle_cnt >= SETTLE_LAST)
      begin
        c_next.ready = 1'b1; // RULE_02
      end
      else
      begin
        c_next.settle_cnt = c_reg.settle_cnt + 16'h0001; // RULE_02
      end
    end
    if (!c_next.ref_en)
    begin
      c_next.ready = 1'b0; // RULE_02
    end

    // reference path to the converter only when enabled and gain not off
    c_next.ref_path_on = c_next.ref_en && (c_next.gain != `VREF_GAIN_OFF); // RULE_04

    // completion: results land for finished and aborted conversions alike
    if (sar_done)
    begin
      if (c_reg.right_just)
      begin
        c_next.res_high = {6'h00, sar_result[9:8]}; // RULE_11
        c_next.res_low  = sar_result[7:0]; // RULE_11
      end
      else
      begin
        c_next.res_high = sar_result[9:2]; // RULE_11
        c_next.res_low  = {sar_result[1:0], 6'h00}; // RULE_11
      end
      c_next.go = 1'b0;
      if (!sar_partial)
      begin
        c_next.done_flag = 1'b1; // RULE_12
      end
    end

    // interrupt and wake follow the sticky flag; wake only while asleep
    c_next.irq  = c_next.done_flag && c_next.irq_en; // RULE_12
    c_next.wake = c_next.done_flag && c_next.irq_en && SLEEP_IN; // RULE_12

    // read data stand in the cycle after the strobe only
    c_next.rd_data = `VREF_RESET_BYTE;
    if (RD_STB_IN)
    begin
      unique case (ADDR_IN)
        `VREF_ADDR_CTRL:
        begin
          c_next.rd_data = ctrl_image(c_reg);
        end
        `VREF_ADDR_RES_HIGH:
        begin
          c_next.rd_data = c_reg.res_high;
        end
        `VREF_ADDR_RES_LOW:
        begin
          c_next.rd_data = c_reg.res_low;
        end
        `VREF_ADDR_CONV:
        begin
          c_next.rd_data = conv_image(c_reg, sar_busy);
        end
        default:
        begin
          c_next.rd_data = `VREF_RESET_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      c_reg <= '0; // RULE_08
    end
    else
    begin
      c_reg <= c_next;
    end
  end

  sar_engine #(
    .BITS (`VREF_RESULT_BITS)
  ) u_sar (
    .clk_in      (CLK_IN),
    .rst_b_in    (RST_B_IN),
    .start_in    (c_reg.start),
    .abort_in    (c_reg.abort),
    .comp_in     (COMP_IN),
    .trial_out   (DAC_TRIAL_OUT),
    .result_out  (sar_result),
    .done_out    (sar_done),
    .partial_out (sar_partial),
    .busy_out    (sar_busy)
  ); // RULE_11

  assign RD_DATA_OUT         = c_reg.rd_data;
  assign REF_ENABLE_OUT      = c_reg.ref_en;
  assign REF_PATH_ON_OUT     = c_reg.ref_path_on;
  assign REF_GAIN_OUT        = c_reg.gain;
  assign TEMP_ENABLE_OUT     = c_reg.temp_en;
  assign TEMP_RANGE_HIGH_OUT = c_reg.temp_range;
  assign CONV_BUSY_OUT       = sar_busy;
  assign CONV_IRQ_OUT        = c_reg.irq;
  assign WAKE_OUT            = c_reg.wake;

endmodule

// ---- testbench/voltage_ref_tempsense_ctrl_checker.sv ----
/*
  concurrent checks on the reference/temperature control block ports.
  assumes single clock domain and bind to the top module.
*/
`timescale 1ns/100ps
module ref_ctrl_checker #(
  parameter bit STANDARD_VARIANT = 1'b0
) (
  input wire logic       CLK_IN,
  input wire logic       RST_B_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WR_DATA_IN,
  input wire logic       WR_STB_IN,
  input wire logic       RD_STB_IN,
  input wire logic       SLEEP_IN,
  input wire logic [7:0] RD_DATA_OUT,
  input wire logic       REF_ENABLE_OUT,
  input wire logic       REF_PATH_ON_OUT,
  input wire logic [1:0] REF_GAIN_OUT,
  input wire logic       TEMP_ENABLE_OUT,
  input wire logic       TEMP_RANGE_HIGH_OUT,
  input wire logic       CONV_BUSY_OUT,
  input wire logic       CONV_IRQ_OUT,
  input wire logic       WAKE_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  sequence ctrl_wr_s;
    WR_STB_IN && ADDR_IN == 8'h00;
  endsequence
  ref_en_a: assert property (ctrl_wr_s |=> REF_ENABLE_OUT == $past(WR_DATA_IN[7]))
    else $error("reference enable does not follow write");
  temp_en_a: assert property (ctrl_wr_s |=> TEMP_ENABLE_OUT == $past(WR_DATA_IN[5]))
    else $error("sensor enable does not follow write");
  range_sel_a: assert property (ctrl_wr_s |=> TEMP_RANGE_HIGH_OUT == $past(WR_DATA_IN[4]))
    else $error("range select does not follow write");
  gain_sel_a: assert property (ctrl_wr_s |=> REF_GAIN_OUT == $past(WR_DATA_IN[1:0]))
    else $error("gain field does not follow write");
  path_on_a: assert property (REF_PATH_ON_OUT == (REF_ENABLE_OUT && REF_GAIN_OUT != 2'h0))
    else $error("reference path on with gain off");
  unimpl_zero_a: assert property (RD_STB_IN && ADDR_IN == 8'h00 |=> RD_DATA_OUT[3:2] == 2'h0)
    else $error("unimplemented bits read nonzero");
  ready_off_a: assert property (RD_STB_IN && ADDR_IN == 8'h00 && !REF_ENABLE_OUT && !STANDARD_VARIANT
    |=> !RD_DATA_OUT[6])
    else $error("ready reads 1 while reference off");
  rd_idle_a: assert property (!RD_STB_IN |=> RD_DATA_OUT == 8'h00)
    else $error("read data outside read slot");
  wake_irq_a: assert property (WAKE_OUT |-> CONV_IRQ_OUT && $past(SLEEP_IN))
    else $error("wake without interrupt or sleep");
  conv_len_a: assert property ($rose(CONV_BUSY_OUT) |-> ##[1:40] !CONV_BUSY_OUT)
    else $error("conversion does not finish");
  cover property (ctrl_wr_s ##1 REF_ENABLE_OUT);
  cover property ($fell(CONV_BUSY_OUT) ##[1:4] CONV_IRQ_OUT);
  cover property (WAKE_OUT);
endmodule

bind voltage_ref_tempsense_ctrl ref_ctrl_checker #(.STANDARD_VARIANT(STANDARD_VARIANT)) chk_i (.*);

// ---- testbench/voltage_ref_tempsense_ctrl_test.sv ----
/*
  self-checking bench for the reference/temperature control block.
  assumes an ideal comparator in the bench and a short settle count.
*/
`timescale 1ns/100ps
module voltage_ref_tempsense_ctrl_test;
  logic       CLK_IN = 1'b0;
  logic       RST_B_IN = 1'b0;
  logic [7:0] ADDR_IN = 8'h00;
  logic [7:0] WR_DATA_IN = 8'h00;
  logic       WR_STB_IN = 1'b0;
  logic       RD_STB_IN = 1'b0;
  logic       SLEEP_IN = 1'b0;
  logic       COMP_IN;
  logic [7:0] RD_DATA_OUT;
  logic       REF_ENABLE_OUT, REF_PATH_ON_OUT, TEMP_ENABLE_OUT, TEMP_RANGE_HIGH_OUT;
  logic [1:0] REF_GAIN_OUT;
  logic [9:0] DAC_TRIAL_OUT;
  logic       CONV_BUSY_OUT, CONV_IRQ_OUT, WAKE_OUT;
  int         bad_count = 0;
  int         checked = 0;
  int         seed = 30109;
  int         vin = 0;
  int         i, n;
  logic [7:0] d, q;

  always #20 CLK_IN = ~CLK_IN;
  // ideal comparator, must answer in the same cycle as the trial code
  assign COMP_IN = (vin >= DAC_TRIAL_OUT);

  voltage_ref_tempsense_ctrl #(.STANDARD_VARIANT(1'b0), .SETTLE_CYCLES(4)) dut (
    .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .ADDR_IN(ADDR_IN), .WR_DATA_IN(WR_DATA_IN),
    .WR_STB_IN(WR_STB_IN), .RD_STB_IN(RD_STB_IN), .COMP_IN(COMP_IN), .SLEEP_IN(SLEEP_IN),
    .RD_DATA_OUT(RD_DATA_OUT), .REF_ENABLE_OUT(REF_ENABLE_OUT), .REF_PATH_ON_OUT(REF_PATH_ON_OUT),
    .REF_GAIN_OUT(REF_GAIN_OUT), .TEMP_ENABLE_OUT(TEMP_ENABLE_OUT),
    .TEMP_RANGE_HIGH_OUT(TEMP_RANGE_HIGH_OUT), .DAC_TRIAL_OUT(DAC_TRIAL_OUT),
    .CONV_BUSY_OUT(CONV_BUSY_OUT), .CONV_IRQ_OUT(CONV_IRQ_OUT), .WAKE_OUT(WAKE_OUT));

  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge CLK_IN);
    ADDR_IN <= a;
    WR_DATA_IN <= v;
    WR_STB_IN <= 1'b1;
    @(posedge CLK_IN);
    WR_STB_IN <= 1'b0;
  endtask

  // data sampled in the single cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge CLK_IN);
    ADDR_IN <= a;
    RD_STB_IN <= 1'b1;
    @(posedge CLK_IN);
    RD_STB_IN <= 1'b0;
    #1 v = RD_DATA_OUT;
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #1000000;
    bad_count++;
    end_of_test();
  end

  initial
  begin
    repeat (5) @(posedge CLK_IN);
    RST_B_IN <= 1'b1;
    rd(8'h00, q);
    chk("ctrl reset", 10'h000, {2'h0, q});
    rd(8'h10, q);
    chk("unmapped", 10'h000, {2'h0, q});
    $display("test reset done");
    for (i = 0; i < 8; i++)
    begin
      d = $random(seed);
      d[1:0] = i[1:0];
      wr(8'h00, d);
      #1;
      chk("ref out", {9'h000, d[7]}, {9'h000, REF_ENABLE_OUT});
      chk("gain out", {8'h00, d[1:0]}, {8'h00, REF_GAIN_OUT});
      chk("temp out", {8'h00, d[5:4]}, {8'h00, TEMP_ENABLE_OUT, TEMP_RANGE_HIGH_OUT});
      repeat (8) @(posedge CLK_IN);
      rd(8'h00, q);
      chk("ctrl read", {2'h0, (d & 8'hB3) | {1'b0, d[7], 6'h00}}, {2'h0, q});
    end
    $display("test fields done");
    wr(8'h00, 8'h00);
    wr(8'h00, 8'h81);
    rd(8'h00, q);
    chk("settling", 10'h002, {8'h00, q[7:6]});
    repeat (5) @(posedge CLK_IN);
    rd(8'h00, q);
    chk("settled", 10'h003, {8'h00, q[7:6]});
    wr(8'h00, 8'h01);
    rd(8'h00, q);
    chk("disabled", 10'h000, {8'h00, q[7:6]});
    wr(8'h00, 8'h81);
    rd(8'h00, q);
    chk("restart", 10'h002, {8'h00, q[7:6]});
    $display("test ready done");
    for (i = 0; i < 2; i++)
    begin
      vin = $random(seed) & 1023;
      SLEEP_IN <= i[0];
      d = i[0] ? 8'h0A : 8'h1A;
      // sensor acquisition wait, 200 us at 40 ns per cycle
      repeat (5000) @(posedge CLK_IN);
      wr(8'h03, d);
      wr(8'h03, d | 8'h01);
      repeat (3) @(posedge CLK_IN);
      n = 0;
      while (CONV_BUSY_OUT === 1'b1 && n < 100)
      begin
        @(posedge CLK_IN);
        n++;
      end
      repeat (2) @(posedge CLK_IN);
      #1 chk("irq", 10'h001, {9'h000, CONV_IRQ_OUT});
      chk("wake", {9'h000, i[0]}, {9'h000, WAKE_OUT});
      rd(8'h01, q);
      chk("res high", i[0] ? vin >> 2 : vin >> 8, {2'h0, q});
      rd(8'h02, q);
      chk("res low", i[0] ? (vin & 3) << 6 : vin & 255, {2'h0, q});
      wr(8'h03, d);
      repeat (2) @(posedge CLK_IN);
      #1 chk("irq clear", 10'h000, {9'h000, CONV_IRQ_OUT});
    end
    $display("test convert done");
    end_of_test();
  end
endmodule
